/* File: glob_cfg_pkg.sv */
package glob_cfg_pkg;

  // register indices on the configuration data port
  localparam logic [7:0] TWO_WIRE_PIN_SELECT_OFS = 8'h2a;
  localparam logic [7:0] RS485_FLOW_CONTROL_OFS = 8'h2b;
  localparam logic [7:0] GPIO_GROUP_FUNCTION_SELECT_OFS = 8'h2c;

  // reset values and writable-bit masks; reserved bits never store
  localparam logic [7:0] TWO_WIRE_RESET = 8'h00;
  localparam logic [7:0] FLOW_RESET = 8'h00;
  localparam logic [7:0] GROUP_FUNC_RESET = 8'h02;
  localparam logic [7:0] TWO_WIRE_WR_MASK = 8'h0e;
  localparam logic [7:0] FLOW_WR_MASK = 8'hff;
  localparam logic [7:0] GROUP_FUNC_WR_MASK = 8'hc7;

  // field positions
  localparam int SDA_BYPASS_BIT = 3;
  localparam int SCL_BYPASS_BIT = 2;
  localparam int PAIR_I2C_BIT = 1;
  localparam int FLOW_EN_LSB = 4;
  localparam int FLOW_INV_LSB = 0;
  localparam int GROUP2_PUSH_PULL_BIT = 7;
  localparam int GROUP1_PUSH_PULL_BIT = 6;
  localparam int THERMAL_EN_BIT = 2;
  localparam int GROUP_FUNC_LSB = 0;

  // pins of the eight-pin group that change role
  localparam int IR_RX_PIN = 4;
  localparam int IR_TX_PIN = 5;

  // glitch filter: a level must stay this long before it is taken
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILTER_NS = 80;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_CNT_W = 3;

  typedef enum logic [1:0] {
    FUNC_GPIO_RSVD = 2'b00,
    FUNC_INFRARED = 2'b01,
    FUNC_ALL_GPIO = 2'b10,
    FUNC_UART = 2'b11
  } group_func_t;

  // configuration port request and answer
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic [7:0] two_wire;
    logic [7:0] flow;
    logic [7:0] gfunc;
    logic [7:0] rdata;
    logic ack;
    logic [2:0] sda_sync;
    logic [2:0] scl_sync;
    logic sda_filt;
    logic scl_filt;
    logic [FILTER_CNT_W-1:0] sda_cnt;
    logic [FILTER_CNT_W-1:0] scl_cnt;
    logic [1:0] pair_lvl;
    logic [2:0][7:0] grp_sync;
    logic [7:0] grp_in;
    logic [7:0] grp_out;
    logic [7:0] grp_oe_n;
    logic [1:0] pair_out;
    logic [1:0] pair_oe_n;
    logic [3:0] send_req_n;
  } state_t;

endpackage

/* File: global_pin_and_flow_config.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 3 of the two-wire pin select register set to one bypasses the data-line glitch filter.
// - Bit 2 of the two-wire pin select register set to one bypasses the clock-line glitch filter.
// - Bit 1 of the two-wire pin select register picks GPIO lines (0) or I2C data/clock (1).
// - Bits 7..4 of the flow register enable auto flow control for UART A, C, D and E.
// - Bits 3..0 of the flow register invert the send-request pin of UART A, C, D and E.
// - A UART's inversion counts only while its auto flow enable is one.
// - Bit 7 of the group function register picks open-drain (0) or push-pull (1) for group two.
// - Bit 6 of the group function register picks open-drain (0) or push-pull (1) for group one.
// - Bit 2 of the group function register enables thermal shutdown.
// - Field 00 makes six pins GPIO, one tri-stated and one held low; field 10 makes all GPIO.
// - Field 01 puts infrared receive and transmit on two pins, the rest stay GPIO.
// - Field 11 hands all eight group pins to the second UART.
// - Reset gives 02h in the group function register and zero in the other two.
// - While the access lock is one, reads and writes of these registers are refused.
module global_pin_and_flow_config (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire glob_cfg_pkg::cfg_req_t cfg_req,
  output glob_cfg_pkg::cfg_rsp_t cfg_rsp,
  input wire logic config_mode_active,
  input wire logic config_access_lock,
  input wire logic [1:0] pair_pin_in,
  output logic [1:0] pair_pin_out,
  output logic [1:0] pair_pin_oe_n,
  input wire logic [1:0] gpio_pair_out,
  input wire logic [1:0] gpio_pair_en,
  output logic gpio_line_five,
  output logic gpio_line_six,
  input wire logic [1:0] i2c_pull_low,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  input wire logic [3:0] uart_tx_active,
  input wire logic [3:0] uart_modem_rts_n,
  output logic uart_a_send_request_n,
  output logic uart_c_send_request_n,
  output logic uart_d_send_request_n,
  output logic uart_e_send_request_n,
  input wire logic [7:0] grp_pin_in,
  output logic [7:0] grp_pin_out,
  output logic [7:0] grp_pin_oe_n,
  input wire logic [7:0] first_gpio_group_out,
  input wire logic [7:0] first_gpio_group_en,
  output logic [7:0] first_gpio_group_in,
  output logic infrared_receive,
  input wire logic infrared_transmit,
  input wire logic [7:0] uart_b_pin_out,
  input wire logic [7:0] uart_b_pin_drive,
  output logic [7:0] uart_b_pin_in,
  output logic group1_push_pull,
  output logic group2_push_pull,
  output logic thermal_shutdown_enable
);

  glob_cfg_pkg::state_t s;
  glob_cfg_pkg::state_t next_s;

  // one filter step: a level is taken once it has stood FILTER_CYCLES agreeing samples
  function automatic logic [glob_cfg_pkg::FILTER_CNT_W:0] filter_step(
    input logic [2:0] sync,
    input logic filt,
    input logic [glob_cfg_pkg::FILTER_CNT_W-1:0] cnt,
    input logic bypass
  );
    logic agree;
    logic [glob_cfg_pkg::FILTER_CNT_W-1:0] last;
    agree = (sync[2] == sync[1]);
    last = glob_cfg_pkg::FILTER_CYCLES[glob_cfg_pkg::FILTER_CNT_W-1:0] - 3'h1;
    if (bypass)
    begin
      filter_step = {agree ? sync[2] : filt, 3'h0};
    end
    else if (agree && (sync[2] != filt))
    begin
      if (cnt == last)
        filter_step = {sync[2], 3'h0};
      else
        filter_step = {filt, cnt + 3'h1};
    end
    else
    begin
      filter_step = {filt, 3'h0};
    end
  endfunction

  logic access_ok;
  logic hit_two_wire;
  logic hit_flow;
  logic hit_gfunc;
  logic [3:0] flow_en;
  logic [3:0] flow_inv;
  glob_cfg_pkg::group_func_t gfunc_sel;

  // the lock is checked here; entering configuration mode is the host's job
  assign access_ok = config_mode_active & ~config_access_lock;
  assign hit_two_wire = cfg_req.index == glob_cfg_pkg::TWO_WIRE_PIN_SELECT_OFS;
  assign hit_flow = cfg_req.index == glob_cfg_pkg::RS485_FLOW_CONTROL_OFS;
  assign hit_gfunc = cfg_req.index == glob_cfg_pkg::GPIO_GROUP_FUNCTION_SELECT_OFS;
  assign flow_en = s.flow[glob_cfg_pkg::FLOW_EN_LSB +: 4];
  assign flow_inv = s.flow[glob_cfg_pkg::FLOW_INV_LSB +: 4] & flow_en;
  assign gfunc_sel = glob_cfg_pkg::group_func_t'(s.gfunc[glob_cfg_pkg::GROUP_FUNC_LSB +: 2]);

  // next-state logic for registers, synchronisers, filters and pin muxes
  always_comb
  begin
    logic mapped;
    logic pp1;
    logic pp2;
    mapped = hit_two_wire | hit_flow | hit_gfunc;
    pp1 = s.gfunc[glob_cfg_pkg::GROUP1_PUSH_PULL_BIT];
    pp2 = s.gfunc[glob_cfg_pkg::GROUP2_PUSH_PULL_BIT];
    next_s = s;
    next_s.ack = access_ok & (cfg_req.wr | cfg_req.rd) & mapped;
    // writes keep only the defined bits; refused accesses change nothing
    if (access_ok && cfg_req.wr)
    begin
      if (hit_two_wire)
        next_s.two_wire = cfg_req.wdata & glob_cfg_pkg::TWO_WIRE_WR_MASK;
      if (hit_flow)
        next_s.flow = cfg_req.wdata & glob_cfg_pkg::FLOW_WR_MASK;
      if (hit_gfunc)
        next_s.gfunc = cfg_req.wdata & glob_cfg_pkg::GROUP_FUNC_WR_MASK;
    end
    // unmapped reads leave the last answer alone, it belongs to whoever acked
    if (access_ok && cfg_req.rd && mapped)
    begin
      next_s.rdata = hit_two_wire ? s.two_wire :
                     hit_flow ? s.flow :
                     hit_gfunc ? s.gfunc : 8'h00;
    end
    // three-stage synchronisers; only stages two and three are looked at
    next_s.sda_sync = {s.sda_sync[1:0], pair_pin_in[0]};
    next_s.scl_sync = {s.scl_sync[1:0], pair_pin_in[1]};
    next_s.grp_sync = {s.grp_sync[1:0], grp_pin_in};
    for (int i = 0; i < 8; i++)
    begin
      if (s.grp_sync[2][i] == s.grp_sync[1][i])
        next_s.grp_in[i] = s.grp_sync[2][i];
    end
    // pair pins read as gpio: a change counts once stages two and three agree
    if (s.sda_sync[2] == s.sda_sync[1])
      next_s.pair_lvl[0] = s.sda_sync[2];
    if (s.scl_sync[2] == s.scl_sync[1])
      next_s.pair_lvl[1] = s.scl_sync[2];
    {next_s.sda_filt, next_s.sda_cnt} = filter_step(s.sda_sync, s.sda_filt, s.sda_cnt,
      s.two_wire[glob_cfg_pkg::SDA_BYPASS_BIT]);
    {next_s.scl_filt, next_s.scl_cnt} = filter_step(s.scl_sync, s.scl_filt, s.scl_cnt,
      s.two_wire[glob_cfg_pkg::SCL_BYPASS_BIT]);
    // pin pair: i2c pulls low only; gpio follows the group-two output type
    if (s.two_wire[glob_cfg_pkg::PAIR_I2C_BIT])
    begin
      next_s.pair_out = 2'h0;
      next_s.pair_oe_n = ~i2c_pull_low;
    end
    else if (pp2)
    begin
      next_s.pair_out = gpio_pair_out;
      next_s.pair_oe_n = ~gpio_pair_en;
    end
    else
    begin
      next_s.pair_out = 2'h0;
      next_s.pair_oe_n = ~(gpio_pair_en & ~gpio_pair_out);
    end
    // group pins: gpio first, then the special roles override
    if (pp1)
    begin
      next_s.grp_out = first_gpio_group_out;
      next_s.grp_oe_n = ~first_gpio_group_en;
    end
    else
    begin
      next_s.grp_out = 8'h00;
      next_s.grp_oe_n = ~(first_gpio_group_en & ~first_gpio_group_out);
    end
    case (gfunc_sel)
      glob_cfg_pkg::FUNC_GPIO_RSVD:
      begin
        next_s.grp_out[glob_cfg_pkg::IR_RX_PIN] = 1'b0;
        next_s.grp_oe_n[glob_cfg_pkg::IR_RX_PIN] = 1'b1;
        next_s.grp_out[glob_cfg_pkg::IR_TX_PIN] = 1'b0;
        next_s.grp_oe_n[glob_cfg_pkg::IR_TX_PIN] = 1'b0;
      end
      glob_cfg_pkg::FUNC_INFRARED:
      begin
        next_s.grp_out[glob_cfg_pkg::IR_RX_PIN] = 1'b0;
        next_s.grp_oe_n[glob_cfg_pkg::IR_RX_PIN] = 1'b1;
        next_s.grp_out[glob_cfg_pkg::IR_TX_PIN] = infrared_transmit;
        next_s.grp_oe_n[glob_cfg_pkg::IR_TX_PIN] = 1'b0;
      end
      glob_cfg_pkg::FUNC_UART:
      begin
        next_s.grp_out = uart_b_pin_out;
        next_s.grp_oe_n = ~uart_b_pin_drive;
      end
      default:
      begin
        next_s.grp_out = next_s.grp_out; // all eight stay gpio
      end
    endcase
    // send-request: with auto flow on, active low while sending and flipped when inversion is on; otherwise uart_modem_rts_n
    for (int u = 0; u < 4; u++)
    begin
      if (flow_en[u])
        next_s.send_req_n[u] = ~uart_tx_active[u] ^ flow_inv[u];
      else
        next_s.send_req_n[u] = uart_modem_rts_n[u];
    end
  end

  // state register; reset values chosen so pins start high-impedance
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.two_wire <= glob_cfg_pkg::TWO_WIRE_RESET;
      s.flow <= glob_cfg_pkg::FLOW_RESET;
      s.gfunc <= glob_cfg_pkg::GROUP_FUNC_RESET;
      s.sda_sync <= 3'h7;
      s.scl_sync <= 3'h7;
      s.sda_filt <= 1'b1;
      s.scl_filt <= 1'b1;
      s.pair_lvl <= 2'h3;
      s.grp_oe_n <= 8'hff;
      s.pair_oe_n <= 2'h3;
      s.send_req_n <= 4'hf;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs, all from the state register
  assign cfg_rsp.ack = s.ack;
  assign cfg_rsp.rdata = s.rdata;
  assign pair_pin_out = s.pair_out;
  assign pair_pin_oe_n = s.pair_oe_n;
  assign i2c_sda_in = s.two_wire[glob_cfg_pkg::PAIR_I2C_BIT] ? s.sda_filt : 1'b1;
  assign i2c_scl_in = s.two_wire[glob_cfg_pkg::PAIR_I2C_BIT] ? s.scl_filt : 1'b1;
  assign gpio_line_five = s.pair_lvl[0];
  assign gpio_line_six = s.pair_lvl[1];
  assign {uart_a_send_request_n, uart_c_send_request_n} = s.send_req_n[3:2];
  assign {uart_d_send_request_n, uart_e_send_request_n} = s.send_req_n[1:0];
  assign grp_pin_out = s.grp_out;
  assign grp_pin_oe_n = s.grp_oe_n;
  assign first_gpio_group_in = s.grp_in;
  assign infrared_receive = (gfunc_sel == glob_cfg_pkg::FUNC_INFRARED) ?
    s.grp_in[glob_cfg_pkg::IR_RX_PIN] : 1'b1;
  assign uart_b_pin_in = (gfunc_sel == glob_cfg_pkg::FUNC_UART) ? s.grp_in : 8'hff;
  assign group1_push_pull = s.gfunc[glob_cfg_pkg::GROUP1_PUSH_PULL_BIT];
  assign group2_push_pull = s.gfunc[glob_cfg_pkg::GROUP2_PUSH_PULL_BIT];
  assign thermal_shutdown_enable = s.gfunc[glob_cfg_pkg::THERMAL_EN_BIT];

  // a single-cycle spike must not pass the active filter
  AST_SDA_FILTER: assert property (@(posedge sys_clk) disable iff (!nrst)
    !s.two_wire[3] && s.sda_cnt == 3'h0 |=> s.sda_filt == $past(s.sda_filt))
    else $error("data filter passed a level too early");
  AST_SCL_BYPASS: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.two_wire[2] && s.scl_sync[2] == s.scl_sync[1] |=> s.scl_filt == $past(s.scl_sync[2]))
    else $error("clock filter bypass did not follow the pin");
  AST_PAIR_I2C: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.two_wire[1] |=> s.pair_out == 2'h0 && s.pair_oe_n == ~$past(i2c_pull_low))
    else $error("pin pair not under i2c control");
  AST_FLOW_PLAIN: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.flow == 8'hf0 |=> s.send_req_n == ~$past(uart_tx_active))
    else $error("send request does not track transmitter");
  AST_FLOW_INVERT: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.flow == 8'hff |=> s.send_req_n == $past(uart_tx_active))
    else $error("send request inversion missing");
  AST_INV_IGNORED: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.flow[7:4] == 4'h0 |=> s.send_req_n == $past(uart_modem_rts_n))
    else $error("inversion applied without auto flow");
  AST_GROUP2_OD: assert property (@(posedge sys_clk) disable iff (!nrst)
    !s.two_wire[1] && !s.gfunc[7] |=> s.pair_out == 2'h0)
    else $error("open-drain pair drove high");
  AST_GROUP1_OD: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.gfunc[1:0] == 2'b10 && !s.gfunc[6] |=> s.grp_out == 8'h00)
    else $error("open-drain group drove high");
  AST_THERMAL: assert property (@(posedge sys_clk) disable iff (!nrst)
    access_ok && cfg_req.wr && hit_gfunc |=> thermal_shutdown_enable == $past(cfg_req.wdata[2]))
    else $error("thermal enable not written");
  AST_RSVD_PINS: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.gfunc[1:0] == 2'b00 |=> s.grp_oe_n[4] && !s.grp_oe_n[5] && !s.grp_out[5])
    else $error("reserved pins not tri-state and low");
  AST_UART_PINS: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.gfunc[1:0] == 2'b11 |=> s.grp_out == $past(uart_b_pin_out))
    else $error("second uart not on group pins");
  AST_LOCKED: assert property (@(posedge sys_clk) disable iff (!nrst)
    config_access_lock && (cfg_req.wr || cfg_req.rd) |=> !s.ack && $stable(s.gfunc))
    else $error("locked access was taken");
  AST_RESERVED: assert property (@(posedge sys_clk) disable iff (!nrst)
    s.two_wire[7:4] == 4'h0 && !s.two_wire[0] && s.gfunc[5:3] == 3'h0)
    else $error("reserved bit stored");

endmodule

/* File: cfg_host_model.sv */
`timescale 1ns/1ps
// host side of the configuration port: one strobe per access, fixed one-cycle answer
module cfg_host_model (
  input wire logic sys_clk,
  input wire glob_cfg_pkg::cfg_rsp_t cfg_rsp,
  output glob_cfg_pkg::cfg_req_t cfg_req,
  output logic config_mode_active
);
  int key_count;

  initial
  begin
    cfg_req = '0;
    config_mode_active = 1'b0;
    key_count = 0;
  end

  // extended mode opens only after the key lands twice in a row
  task automatic enter_mode();
    key_count = 0;
    repeat (2)
    begin
      @(posedge sys_clk);
      key_count++;
    end
    config_mode_active <= (key_count == 2);
  endtask

  task automatic leave_mode();
    @(posedge sys_clk);
    config_mode_active <= 1'b0;
  endtask

  // index and data are scrambled once taken, so a late sample shows garbage
  task automatic access(input logic wr, input logic rd, input logic [7:0] idx,
    input logic [7:0] wd, output logic ack, output logic [7:0] rdata);
    @(posedge sys_clk);
    cfg_req <= '{wr: wr, rd: rd, index: idx, wdata: wd};
    @(posedge sys_clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~wd};
    #1;
    ack = cfg_rsp.ack;
    rdata = cfg_rsp.rdata;
  endtask
endmodule

/* File: global_pin_and_flow_config_tb.sv */
`timescale 1ns/1ps
module global_pin_and_flow_config_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic lock = 1'b0;
  logic [1:0] pair_in = 2'b11;
  logic [1:0] pull_low = 2'b00;
  logic [1:0] pair_en = 2'b00;
  logic [3:0] tx_act = 4'h0;
  logic [3:0] rts_n = 4'h9;
  logic [7:0] grp_in = 8'ha5;
  logic ir_tx = 1'b1;
  glob_cfg_pkg::cfg_req_t cfg_req;
  glob_cfg_pkg::cfg_rsp_t cfg_rsp;
  logic mode;
  logic [1:0] pair_out;
  logic [1:0] pair_oe_n;
  logic line5;
  logic line6;
  logic sda_in;
  logic scl_in;
  logic [3:0] sreq_n;
  logic [7:0] grp_out;
  logic [7:0] grp_oe_n;
  logic [7:0] gpio_in;
  logic ir_rx;
  logic [7:0] ub_in;
  logic pp1;
  logic pp2;
  logic therm;
  int bad_count = 0;
  int checks_done = 0;

  always #10 sys_clk = ~sys_clk;

  cfg_host_model cfg_host_model_inst (.sys_clk(sys_clk), .cfg_rsp(cfg_rsp),
    .cfg_req(cfg_req), .config_mode_active(mode));

  global_pin_and_flow_config global_pin_and_flow_config_inst (.sys_clk(sys_clk), .nrst(nrst),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .config_mode_active(mode),
    .config_access_lock(lock), .pair_pin_in(pair_in), .pair_pin_out(pair_out),
    .pair_pin_oe_n(pair_oe_n), .gpio_pair_out(2'b11), .gpio_pair_en(pair_en),
    .gpio_line_five(line5), .gpio_line_six(line6), .i2c_pull_low(pull_low),
    .i2c_sda_in(sda_in), .i2c_scl_in(scl_in), .uart_tx_active(tx_act),
    .uart_modem_rts_n(rts_n), .uart_a_send_request_n(sreq_n[3]),
    .uart_c_send_request_n(sreq_n[2]), .uart_d_send_request_n(sreq_n[1]),
    .uart_e_send_request_n(sreq_n[0]), .grp_pin_in(grp_in), .grp_pin_out(grp_out),
    .grp_pin_oe_n(grp_oe_n), .first_gpio_group_out(8'h20), .first_gpio_group_en(8'hff),
    .first_gpio_group_in(gpio_in), .infrared_receive(ir_rx), .infrared_transmit(ir_tx),
    .uart_b_pin_out(8'h5a), .uart_b_pin_drive(8'h3c), .uart_b_pin_in(ub_in),
    .group1_push_pull(pp1), .group2_push_pull(pp2), .thermal_shutdown_enable(therm));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // a read expects d back; a refused access must stay silent
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic ea);
    logic a;
    logic [7:0] r;
    cfg_host_model_inst.access(w, ~w, idx, d, a, r);
    chk({7'h0, a}, {7'h0, ea}, "ack");
    if (!w && ea)
      chk(r, d, "rdata");
  endtask

  task automatic reset_values();
    xfer(1'b0, 8'h2a, 8'h00, 1'b1);
    xfer(1'b0, 8'h2b, 8'h00, 1'b1);
    xfer(1'b0, 8'h2c, 8'h02, 1'b1);
    chk({5'h0, pp2, pp1, therm}, 8'h00, "type bits at reset");
  endtask

  // reserved bits drop, then each output-type and thermal bit alone
  task automatic reserved_and_types();
    logic [7:0] wv[3] = '{8'h40, 8'h80, 8'h06};
    logic [7:0] ev[3] = '{8'h02, 8'h04, 8'h01};
    xfer(1'b1, 8'h2a, 8'hff, 1'b1);
    xfer(1'b0, 8'h2a, 8'h0e, 1'b1);
    xfer(1'b1, 8'h2c, 8'hff, 1'b1);
    xfer(1'b0, 8'h2c, 8'hc7, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, 8'h2c, wv[i], 1'b1);
      cyc(1);
      chk({5'h0, pp2, pp1, therm}, ev[i], "type bits");
    end
  endtask

  task automatic refusals();
    @(posedge sys_clk);
    lock <= 1'b1;
    xfer(1'b1, 8'h2b, 8'hff, 1'b0);
    xfer(1'b0, 8'h2b, 8'h00, 1'b0);
    @(posedge sys_clk);
    lock <= 1'b0;
    cfg_host_model_inst.leave_mode();
    xfer(1'b1, 8'h2b, 8'hff, 1'b0);
    cfg_host_model_inst.enter_mode();
    xfer(1'b1, 8'h30, 8'hff, 1'b0);
    xfer(1'b0, 8'h2b, 8'h00, 1'b1);
  endtask

  task automatic flow_control();
    logic [7:0] fv[4] = '{8'hf0, 8'hff, 8'h0f, 8'ha5};
    logic [3:0] tv[2] = '{4'h6, 4'hb};
    logic [3:0] en;
    logic [3:0] exp;
    for (int i = 0; i < 4; i++)
      for (int t = 0; t < 2; t++)
      begin
        xfer(1'b1, 8'h2b, fv[i], 1'b1);
        @(posedge sys_clk);
        tx_act <= tv[t];
        cyc(3);
        en = fv[i][7:4];
        exp = (en & (~tv[t] ^ fv[i][3:0])) | (~en & rts_n);
        chk({4'h0, sreq_n}, {4'h0, exp}, "send request");
      end
  endtask

  task automatic group_modes();
    logic [7:0] eo[4] = '{8'h00, 8'h20, 8'h00, 8'h5a};
    logic [7:0] ee[4] = '{8'h10, 8'h10, 8'h20, 8'hc3};
    for (int f = 0; f < 4; f++)
    begin
      xfer(1'b1, 8'h2c, 8'(f), 1'b1);
      cyc(5);
      chk(grp_out, eo[f], "group out");
      chk(grp_oe_n, ee[f], "group oe_n");
      chk({7'h0, ir_rx}, {7'h0, f != 1}, "ir receive");
      chk(ub_in, (f == 3) ? 8'ha5 : 8'hff, "uart b in");
      chk(gpio_in, 8'ha5, "gpio in");
    end
  endtask

  task automatic pair_select();
    @(posedge sys_clk);
    pair_in <= 2'b10;
    pull_low <= 2'b01;
    pair_en <= 2'b11;
    xfer(1'b1, 8'h2a, 8'h00, 1'b1);
    cyc(5);
    chk({4'h0, line6, line5, scl_in, sda_in}, 8'h0b, "gpio pair");
    // open-drain: a high value releases the pins even with the enable on
    chk({6'h0, pair_oe_n}, 8'h03, "gpio pair oe");
    xfer(1'b1, 8'h2c, 8'h82, 1'b1);
    cyc(2);
    chk({4'h0, pair_oe_n, pair_out}, 8'h03, "push-pull pair drive");
    xfer(1'b1, 8'h2a, 8'h02, 1'b1);
    cyc(2);
    chk({4'h0, pair_oe_n, pair_out}, 8'h08, "i2c pair drive");
  endtask

  // a short low pulse passes only a bypassed input; a long one passes both
  task automatic glitch(input logic [7:0] cfg, input int len, input logic [1:0] exp);
    logic [1:0] seen;
    xfer(1'b1, 8'h2a, cfg, 1'b1);
    @(posedge sys_clk);
    pair_in <= 2'b11;
    cyc(10);
    seen = 2'b00;
    @(posedge sys_clk);
    pair_in <= 2'b00;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (i == len - 1)
        pair_in <= 2'b11;
      #1;
      seen = seen | {scl_in === 1'b0, sda_in === 1'b0};
    end
    chk({6'h0, seen}, {6'h0, exp}, "filter");
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    cfg_host_model_inst.enter_mode();
    reset_values();
    reserved_and_types();
    refusals();
    flow_control();
    group_modes();
    pair_select();
    glitch(8'h02, 2, 2'b00);
    glitch(8'h0a, 2, 2'b01);
    glitch(8'h06, 2, 2'b10);
    glitch(8'h02, 8, 2'b11);
    test_done();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end
endmodule
